// ===== gpt_defines.svh
`ifndef GPT_DEFINES_SVH
`define GPT_DEFINES_SVH

// ****************************************************************
// Register word addresses
// ****************************************************************
`define ADDR_W      4
`define A_CNT0      4'h0
`define A_CTL0      4'h5
`define A_CAPTURE_RELOAD_REGISTER    4'hA
`define A_CAPCTL    4'hB
`define A_IRQ_ST    4'hC
`define A_IRQ_MSK   4'hD
`define A_LATCH     4'hE
`define N_TIM       5

// ****************************************************************
// Timer indices
// ****************************************************************
`define I_AUX_LO    0
`define I_CORE      1
`define I_AUX_HI    2
`define I_SLAVE     3
`define I_MASTER    4

// ****************************************************************
// Timer control fields
// ****************************************************************
`define F_PRE_LO    0
`define F_PRE_HI    2
`define F_MODE_LO   3
`define F_MODE_HI   4
`define F_RUN       5
`define F_DOWN      6
`define F_XDIR      7
`define F_EDGE_LO   8
`define F_EDGE_HI   9
`define F_LCLK      10
`define F_GATE_HI   11
`define F_AUX_LO    12
`define F_AUX_HI    13
`define F_TOUT      14

// ****************************************************************
// Capture control fields and codes
// ****************************************************************
`define C_EDGE_LO   0
`define C_EDGE_HI   1
`define C_SRC_LO    2
`define C_SRC_HI    3
`define C_CLR       4
`define C_RLD       5
`define AUX_RELOAD  2'b01
`define AUX_CAPTURE 2'b10
`define SRC_CAP_PIN 2'b00
`define SRC_CORE_IN 2'b01
`define SRC_CORE_DR 2'b10

// ****************************************************************
// Widths, prescaler bases and reset values
// ****************************************************************
`define PRE_W       10
`define M1_PRE_BASE 4'h3
`define M2_PRE_BASE 4'h2
`define CNT_MAX     16'hFFFF
`define CNT_ZERO    16'h0000
`define CNT_ONE     16'h0001
`define RST16       16'h0000
`define RST6        6'h00
`define RST5        5'h00
`define RST_PRE     10'h000

`endif

// ===== gpt_pkg.sv
package gpt_pkg;

   // Basic counting modes of each timer.
   typedef enum logic [1:0] {
      MODE_TIMER   = 2'b00,
      MODE_GATED   = 2'b01,
      MODE_COUNTER = 2'b10,
      MODE_INCR    = 2'b11
   } timer_mode_t;

   typedef logic [15:0] word_t;

endpackage

// ===== dual_module_gp_timers.sv
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "gpt_defines.svh"

module dual_module_gp_timers (
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic                 clk_en,
   input  wire logic [`ADDR_W-1:0]   addr,
   input  wire gpt_pkg::word_t       wr_data,
   input  wire logic                 wr_stb,
   input  wire logic                 rd_stb,
   output      gpt_pkg::word_t       rd_data,
   input  wire logic [`N_TIM-1:0]    timer_gate_clock_pin,
   input  wire logic [`N_TIM-1:0]    timer_direction_pin,
   input  wire logic                 capture_trigger_pin,
   output      logic                 toggle_latch_output_pin,
   output      logic                 master_toggle_output_pin,
   output      logic                 compare_unit_clock,
   output      logic                 irq
);
   import gpt_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   word_t                cnt_r [`N_TIM];
   word_t                cnt_nxt [`N_TIM];
   word_t                ctl_r [`N_TIM];
   word_t                capture_reload_register_r;
   logic [5:0]           capctl_r;
   logic [5:0]           irq_st_r;
   logic [5:0]           irq_msk_r;
   logic [`PRE_W-1:0]    pre_r;
   logic [`N_TIM-1:0]    gate_q_r;
   logic [`N_TIM-1:0]    dir_q_r;
   logic                 cap_q_r;
   logic                 core_ltl_r;
   logic                 core_ltl_q_r;
   logic                 master_ltl_r;
   logic                 master_ltl_q_r;
   logic [`N_TIM-1:0]    cnt_en;
   logic [`N_TIM-1:0]    cnt_down;
   logic [`N_TIM-1:0]    wrap;
   logic [`N_TIM-1:0]    aux_edge;
   logic                 cap_trig;
   logic [5:0]           events;
   logic                 core_ltl_edge;
   logic                 master_ltl_edge;

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Selected edge: bit 0 rising, bit 1 falling, both for any change.
   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic       prev,
                                     input logic       cur);
      edge_hit = (sel[0] & ~prev & cur) | (sel[1] & prev & ~cur);
   endfunction

   // A tick of factor 2^(sel+base) fires when all low bits are ones.
   function automatic logic pre_tick(input logic [2:0]        sel,
                                     input logic [3:0]        base,
                                     input logic [`PRE_W-1:0] pre);
      logic [3:0]        k;
      logic [`PRE_W-1:0] msk;
      k   = 4'({1'b0, sel}) + base;
      msk = `PRE_W'((11'h001 << k) - 11'h001);
      pre_tick = ((pre | ~msk) == {`PRE_W{1'b1}});
   endfunction

   assign core_ltl_edge   = core_ltl_r ^ core_ltl_q_r;
   assign master_ltl_edge = master_ltl_r ^ master_ltl_q_r;

   // ****************************************************************
   // Count enable and direction for each timer
   // ****************************************************************

   // Module one has three timers, module two the last two.
   always_comb begin
      for (int i = 0; i < `N_TIM; i++) begin
         logic        tick;
         logic        pin;
         logic        a_chg;
         logic        b_chg;
         logic        lsrc;
         timer_mode_t md;
         tick  = 1'b0;
         pin   = timer_gate_clock_pin[i];
         a_chg = pin ^ gate_q_r[i];
         b_chg = timer_direction_pin[i] ^ dir_q_r[i];
         lsrc  = (i == `I_SLAVE) ? master_ltl_edge : core_ltl_edge;
         md    = timer_mode_t'(ctl_r[i][`F_MODE_HI:`F_MODE_LO]);
         if (i < `I_SLAVE) begin
            tick = pre_tick(ctl_r[i][`F_PRE_HI:`F_PRE_LO],
                            `M1_PRE_BASE, pre_r);
         end else begin
            tick = pre_tick(ctl_r[i][`F_PRE_HI:`F_PRE_LO],
                            `M2_PRE_BASE, pre_r);
         end
         // Software direction, optionally flipped by the pin.
         cnt_down[i] = ctl_r[i][`F_DOWN] ^
                       (ctl_r[i][`F_XDIR] & timer_direction_pin[i]);
         aux_edge[i] = edge_hit(ctl_r[i][`F_EDGE_HI:`F_EDGE_LO],
                                gate_q_r[i], pin);
         cnt_en[i] = 1'b0;
         unique case (md)
            MODE_TIMER: cnt_en[i] = tick;
            MODE_GATED:
               cnt_en[i] = tick & (pin == ctl_r[i][`F_GATE_HI]);
            MODE_COUNTER: begin
               // The latch source chains timers of one module.
               if (ctl_r[i][`F_LCLK] && i != `I_CORE &&
                   i != `I_MASTER) begin
                  cnt_en[i] = lsrc;
               end else begin
                  cnt_en[i] = aux_edge[i];
               end
            end
            MODE_INCR: begin
               if (i < `I_SLAVE) begin
                  // A leads B counts up, B leads A counts down.
                  cnt_en[i] = a_chg | b_chg;
                  cnt_down[i] = a_chg ?
                     (pin == timer_direction_pin[i]) :
                     (pin != timer_direction_pin[i]);
               end else begin
                  cnt_en[i] = aux_edge[i];
               end
            end
         endcase
         // Aux timers acting as reload or capture registers stop.
         if ((i == `I_AUX_LO || i == `I_AUX_HI) &&
             ctl_r[i][`F_AUX_HI:`F_AUX_LO] != 2'b00) begin
            cnt_en[i] = 1'b0;
         end
         cnt_en[i] = cnt_en[i] & ctl_r[i][`F_RUN];
      end
   end

   // ****************************************************************
   // Capture trigger into the capture/reload register
   // ****************************************************************

   // The edge selection applies to whichever source is chosen.
   always_comb begin
      logic [1:0] es;
      logic       c_in;
      logic       c_dr;
      es   = capctl_r[`C_EDGE_HI:`C_EDGE_LO];
      c_in = edge_hit(es, gate_q_r[`I_CORE],
                      timer_gate_clock_pin[`I_CORE]);
      c_dr = edge_hit(es, dir_q_r[`I_CORE],
                      timer_direction_pin[`I_CORE]);
      unique case (capctl_r[`C_SRC_HI:`C_SRC_LO])
         `SRC_CAP_PIN:
            cap_trig = edge_hit(es, cap_q_r, capture_trigger_pin);
         `SRC_CORE_IN: cap_trig = c_in;
         `SRC_CORE_DR: cap_trig = c_dr;
         default:      cap_trig = c_in | c_dr;
      endcase
   end

   // ****************************************************************
   // Next counter values
   // ****************************************************************

   // Order: count, then chaining overrides, then software write.
   always_comb begin
      for (int i = 0; i < `N_TIM; i++) begin
         cnt_nxt[i] = cnt_r[i];
         wrap[i]    = 1'b0;
         if (cnt_en[i]) begin
            if (cnt_down[i]) begin
               wrap[i]    = (cnt_r[i] == `CNT_ZERO);
               cnt_nxt[i] = cnt_r[i] - `CNT_ONE;
            end else begin
               wrap[i]    = (cnt_r[i] == `CNT_MAX);
               cnt_nxt[i] = cnt_r[i] + `CNT_ONE;
            end
         end
      end
      // Aux timers reload the core timer when it wraps.
      if (wrap[`I_CORE]) begin
         if (ctl_r[`I_AUX_HI][`F_AUX_HI:`F_AUX_LO] == `AUX_RELOAD) begin
            cnt_nxt[`I_CORE] = cnt_r[`I_AUX_HI];
         end
         if (ctl_r[`I_AUX_LO][`F_AUX_HI:`F_AUX_LO] == `AUX_RELOAD) begin
            cnt_nxt[`I_CORE] = cnt_r[`I_AUX_LO];
         end
      end
      // Aux timers capture the core timer on their own pin edge.
      for (int i = 0; i <= `I_AUX_HI; i += 2) begin
         if (ctl_r[i][`F_AUX_HI:`F_AUX_LO] == `AUX_CAPTURE &&
             aux_edge[i]) begin
            cnt_nxt[i] = cnt_r[`I_CORE];
         end
      end
      if (wrap[`I_MASTER] && capctl_r[`C_RLD]) begin
         cnt_nxt[`I_MASTER] = capture_reload_register_r;
      end
      if (cap_trig && capctl_r[`C_CLR]) begin
         cnt_nxt[`I_SLAVE] = `CNT_ZERO;
      end
      for (int i = 0; i < `N_TIM; i++) begin
         if (wr_stb && addr == `ADDR_W'(`A_CNT0 + i)) begin
            cnt_nxt[i] = wr_data;
         end
      end
   end

   assign events = {cap_trig, wrap};

   // ****************************************************************
   // Counters and prescaler
   // ****************************************************************

   // The shared divider runs free; each timer taps its own factor.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pre_r <= `RST_PRE;
      end else if (clk_en) begin
         pre_r <= pre_r + `PRE_W'(1);
      end
   end

   // Five 16-bit counters, linked by reload, capture and clearing.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < `N_TIM; i++) begin
            cnt_r[i] <= `RST16;
         end
      end else if (clk_en) begin
         for (int i = 0; i < `N_TIM; i++) begin
            cnt_r[i] <= cnt_nxt[i];
         end
      end
   end

   // Previous pin levels for edge and quadrature detection.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gate_q_r <= `RST5;
         dir_q_r  <= `RST5;
         cap_q_r  <= 1'b0;
      end else if (clk_en) begin
         gate_q_r <= timer_gate_clock_pin;
         dir_q_r  <= timer_direction_pin;
         cap_q_r  <= capture_trigger_pin;
      end
   end

   // ****************************************************************
   // Toggle latches and their outputs
   // ****************************************************************

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         core_ltl_r     <= 1'b0;
         core_ltl_q_r   <= 1'b0;
         master_ltl_r   <= 1'b0;
         master_ltl_q_r <= 1'b0;
      end else if (clk_en) begin
         core_ltl_r     <= core_ltl_r ^ wrap[`I_CORE];
         core_ltl_q_r   <= core_ltl_r;
         master_ltl_r   <= master_ltl_r ^ wrap[`I_MASTER];
         master_ltl_q_r <= master_ltl_r;
      end
   end

   // Pins show the latch only when enabled, so they idle low.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         toggle_latch_output_pin  <= 1'b0;
         master_toggle_output_pin <= 1'b0;
         compare_unit_clock       <= 1'b0;
      end else if (clk_en) begin
         toggle_latch_output_pin  <= core_ltl_r &
                                     ctl_r[`I_CORE][`F_TOUT];
         master_toggle_output_pin <= master_ltl_r &
                                     ctl_r[`I_MASTER][`F_TOUT];
         compare_unit_clock       <= wrap[`I_MASTER];
      end
   end

   // ****************************************************************
   // Capture/reload register and control registers
   // ****************************************************************

   // A capture in the same cycle as a write wins, keeping the event.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         capture_reload_register_r <= `RST16;
      end else if (clk_en) begin
         if (cap_trig) begin
            capture_reload_register_r <= cnt_r[`I_SLAVE];
         end else if (wr_stb && addr == `A_CAPTURE_RELOAD_REGISTER) begin
            capture_reload_register_r <= wr_data;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < `N_TIM; i++) begin
            ctl_r[i] <= `RST16;
         end
         capctl_r  <= `RST6;
         irq_msk_r <= `RST6;
      end else if (clk_en && wr_stb) begin
         for (int i = 0; i < `N_TIM; i++) begin
            if (addr == `ADDR_W'(`A_CTL0 + i)) begin
               ctl_r[i] <= wr_data;
            end
         end
         if (addr == `A_CAPCTL) begin
            capctl_r <= wr_data[5:0];
         end
         if (addr == `A_IRQ_MSK) begin
            irq_msk_r <= wr_data[5:0];
         end
      end
   end

   // ****************************************************************
   // Interrupt status
   // ****************************************************************

   // Writing one clears a bit; a new event in that cycle still sets.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_st_r <= `RST6;
         irq      <= 1'b0;
      end else if (clk_en) begin
         if (wr_stb && addr == `A_IRQ_ST) begin
            irq_st_r <= (irq_st_r & ~wr_data[5:0]) | events;
         end else begin
            irq_st_r <= irq_st_r | events;
         end
         irq <= |(irq_st_r & irq_msk_r);
      end
   end

   // ****************************************************************
   // Read port
   // ****************************************************************

   // Data stands for one cycle after the strobe, else reads zero.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_data <= `RST16;
      end else if (clk_en) begin
         rd_data <= `RST16;
         if (rd_stb) begin
            for (int i = 0; i < `N_TIM; i++) begin
               if (addr == `ADDR_W'(`A_CNT0 + i)) begin
                  rd_data <= cnt_r[i];
               end
               if (addr == `ADDR_W'(`A_CTL0 + i)) begin
                  rd_data <= ctl_r[i];
               end
            end
            unique case (addr)
               `A_CAPTURE_RELOAD_REGISTER:  rd_data <= capture_reload_register_r;
               `A_CAPCTL:  rd_data <= {10'h000, capctl_r};
               `A_IRQ_ST:  rd_data <= {10'h000, irq_st_r};
               `A_IRQ_MSK: rd_data <= {10'h000, irq_msk_r};
               `A_LATCH:   rd_data <= {14'h0000, master_ltl_r, core_ltl_r};
               default:    ;
            endcase
         end
      end
   end

endmodule

// ===== gpt_monitor.sv
`timescale 1ns/1ps
`include "gpt_defines.svh"

// ****************************************************************
// Port-level checker for the timer unit
// ****************************************************************
module gpt_monitor (
   input wire logic                 clk,
   input wire logic                 sys_rst,
   input wire logic                 clk_en,
   input wire logic [`ADDR_W-1:0]   addr,
   input wire gpt_pkg::word_t       wr_data,
   input wire logic                 wr_stb,
   input wire logic                 rd_stb,
   input wire gpt_pkg::word_t       rd_data,
   input wire logic [`N_TIM-1:0]    timer_gate_clock_pin,
   input wire logic [`N_TIM-1:0]    timer_direction_pin,
   input wire logic                 capture_trigger_pin,
   input wire logic                 toggle_latch_output_pin,
   input wire logic                 master_toggle_output_pin,
   input wire logic                 compare_unit_clock,
   input wire logic                 irq
);
   // One clock domain, so clock and reset are given once.
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_rd_idle:
   assert property (!rd_stb && clk_en |=> rd_data == 16'h0000)
      else $error("read data not idle");
   chk_unmapped_read:
   assert property (rd_stb && clk_en && addr == 4'hF |=> rd_data == 16'h0000)
      else $error("unmapped read not zero");
   chk_latch_width:
   assert property (rd_stb && clk_en && addr == `A_LATCH
                    |=> rd_data[15:2] == 14'h0000)
      else $error("latch read has upper bits");
   chk_reset_quiet:
   assert property ($past(sys_rst) |-> !irq && !compare_unit_clock
                    && rd_data == 16'h0000)
      else $error("outputs not quiet after reset");
   chk_cmp_pulse:
   assert property (compare_unit_clock && clk_en |=> !compare_unit_clock)
      else $error("compare clock pulse too long");
   chk_irq_masked:
   assert property (wr_stb && clk_en && addr == `A_IRQ_MSK
                    && wr_data == 16'h0000
                    ##1 !(wr_stb && addr == `A_IRQ_MSK) && clk_en |=> !irq)
      else $error("irq high with mask clear");
   chk_core_pin_off:
   assert property (wr_stb && clk_en && addr == 4'h6 && !wr_data[14]
                    ##1 !(wr_stb && addr == 4'h6) && clk_en
                    |=> !toggle_latch_output_pin)
      else $error("core toggle pin driven while disabled");
   chk_master_pin_off:
   assert property (wr_stb && clk_en && addr == 4'h9 && !wr_data[14]
                    ##1 !(wr_stb && addr == 4'h9) && clk_en
                    |=> !master_toggle_output_pin)
      else $error("master toggle pin driven while disabled");
endmodule

bind dual_module_gp_timers gpt_monitor gpt_monitor_inst (
   .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .addr(addr),
   .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
   .timer_gate_clock_pin(timer_gate_clock_pin),
   .timer_direction_pin(timer_direction_pin),
   .capture_trigger_pin(capture_trigger_pin),
   .toggle_latch_output_pin(toggle_latch_output_pin),
   .master_toggle_output_pin(master_toggle_output_pin),
   .compare_unit_clock(compare_unit_clock), .irq(irq));

// ===== gpt_pin_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Sensor and signal source on the timer pins
// ****************************************************************
module gpt_pin_model (
   input  wire logic       clk,
   output      logic [4:0] gate_pin,
   output      logic [4:0] dir_pin,
   output      logic       cap_pin
);
   // Lines 0-4 gate or count, 5-9 direction, 10 capture.
   logic [10:0] lines = 11'h000;
   assign gate_pin = lines[4:0];
   assign dir_pin  = lines[9:5];
   assign cap_pin  = lines[10];

   // Each level stands three cycles, so the sampler never misses an edge.
   task automatic set(input int ln, input logic v);
      @(posedge clk);
      lines[ln] <= v;
      repeat (2) @(posedge clk);
   endtask

   // Full pulses on one line; the count only moves on selected edges.
   task automatic pulse(input int ln, input int n);
      for (int i = 0; i < n; i++) begin
         set(ln, 1'b1);
         set(ln, 1'b0);
      end
   endtask

   // One quadrature period on the core pins, A leading when forward.
   task automatic quad(input logic fwd);
      if (fwd) begin
         set(1, 1'b1); set(6, 1'b1); set(1, 1'b0); set(6, 1'b0);
      end else begin
         set(6, 1'b1); set(1, 1'b1); set(6, 1'b0); set(1, 1'b0);
      end
   endtask
endmodule

// ===== dual_module_gp_timers_bench.sv
`timescale 1ns/1ps
`include "gpt_defines.svh"

// ****************************************************************
// Self-checking bench for the timer unit
// ****************************************************************
module dual_module_gp_timers_bench;
   import gpt_pkg::*;
   logic              clk = 1'b0;
   logic              sys_rst = 1'b1;
   logic              clk_en = 1'b1;
   logic [3:0]        addr = 4'h0;
   word_t             wr_data = 16'h0000;
   logic              wr_stb = 1'b0;
   logic              rd_stb = 1'b0;
   word_t             rd_data;
   logic [4:0]        gate_pin, dir_pin;
   logic              cap_pin, tpin, mpin, cmp_clk, irq;
   int                bad_count = 0;
   int                num_checks = 0;
   int                cmp_pulses = 0;
   word_t             v;

   always #10 clk = ~clk;

   dual_module_gp_timers dual_module_gp_timers_inst (
      .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .addr(addr),
      .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rd_data(rd_data), .timer_gate_clock_pin(gate_pin),
      .timer_direction_pin(dir_pin), .capture_trigger_pin(cap_pin),
      .toggle_latch_output_pin(tpin), .master_toggle_output_pin(mpin),
      .compare_unit_clock(cmp_clk), .irq(irq));
   gpt_pin_model gpt_pin_model_inst (
      .clk(clk), .gate_pin(gate_pin), .dir_pin(dir_pin), .cap_pin(cap_pin));

   // Sampled mid-cycle so the registered pulse is settled.
   always @(negedge clk) begin
      if (cmp_clk === 1'b1) cmp_pulses++;
   end

   task automatic wr(input logic [3:0] a, input word_t d);
      @(posedge clk);
      addr <= a; wr_data <= d; wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe.
   task automatic rd(input logic [3:0] a, output word_t d);
      @(posedge clk);
      addr <= a; rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 d = rd_data;
   endtask
   task automatic chk_word(input string nm, input word_t e, input word_t g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_range(input string nm, input word_t lo, input word_t hi,
                            input word_t g);
      num_checks++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         bad_count++;
         $display("mismatch %s expected %h..%h seen %h", nm, lo, hi, g);
      end
   endtask
   task automatic rc(input string nm, input logic [3:0] a, input word_t e);
      rd(a, v);
      chk_word(nm, e, v);
   endtask
   task automatic rr(input string nm, input logic [3:0] a, input word_t lo,
                     input word_t hi);
      rd(a, v);
      chk_range(nm, lo, hi, v);
   endtask
   // Runs a timer from zero for a fixed span; expect span over factor.
   task automatic rate(input int i, input word_t ctl, input int span,
                       input word_t lo, input word_t hi);
      wr(`A_CNT0 + 4'(i), 16'h0000);
      wr(`A_CTL0 + 4'(i), ctl);
      repeat (span) @(posedge clk);
      wr(`A_CTL0 + 4'(i), 16'h0000);
      rr("timer rate", `A_CNT0 + 4'(i), lo, hi);
   endtask
   task automatic test_end(input string nm);
      $display("test %s done", nm);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Whole run is near 4300 cycles; a hang is cut well beyond that.
   initial begin
      repeat (40000) @(posedge clk);
      bad_count++;
      final_report();
   end

   // Main sequence.
   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      rc("status", `A_IRQ_ST, 16'h0000);
      rc("latches", `A_LATCH, 16'h0000);
      rc("unmapped", 4'hF, 16'h0000);
      for (int i = 0; i < 5; i++) begin
         wr(`A_CNT0 + 4'(i), 16'hA5A0 + 16'(i));
         rc("counter", `A_CNT0 + 4'(i), 16'hA5A0 + 16'(i));
      end
      test_end("registers");
      rate(0, 16'h0022, 3200, 16'h0063, 16'h0065);
      rate(4, 16'h0020, 400, 16'h0063, 16'h0065);
      test_end("prescalers");
      wr(`A_CNT0, 16'h0000);
      wr(`A_CTL0, 16'h0130);
      gpt_pin_model_inst.pulse(0, 5);
      rc("pin count", `A_CNT0, 16'h0005);
      wr(`A_CNT0 + 4'h2, 16'h0000);
      wr(`A_CTL0 + 4'h2, 16'h0828);
      repeat (100) @(posedge clk);
      rc("gate closed", `A_CNT0 + 4'h2, 16'h0000);
      gpt_pin_model_inst.set(2, 1'b1);
      repeat (78) @(posedge clk);
      wr(`A_CTL0 + 4'h2, 16'h0800);
      rr("gate open", `A_CNT0 + 4'h2, 16'h0009, 16'h000B);
      wr(`A_CNT0 + 4'h1, 16'h0000);
      wr(`A_CTL0 + 4'h1, 16'h0038);
      gpt_pin_model_inst.quad(1'b1);
      gpt_pin_model_inst.quad(1'b1);
      rc("quad fwd", `A_CNT0 + 4'h1, 16'h0008);
      gpt_pin_model_inst.quad(1'b0);
      rc("quad back", `A_CNT0 + 4'h1, 16'h0004);
      test_end("external modes");
      wr(`A_IRQ_MSK, 16'h0002);
      wr(`A_CNT0 + 4'h1, 16'hFFFF);
      wr(`A_CTL0 + 4'h1, 16'h4020);
      repeat (12) @(posedge clk);
      wr(`A_CTL0 + 4'h1, 16'h4000);
      rc("wrap status", `A_IRQ_ST, 16'h0002);
      rc("core latch", `A_LATCH, 16'h0001);
      chk_word("core pin", 16'h0001, {15'h0000, tpin});
      chk_word("irq set", 16'h0001, {15'h0000, irq});
      wr(`A_IRQ_ST, 16'h003F);
      repeat (2) @(posedge clk);
      chk_word("irq clear", 16'h0000, {15'h0000, irq});
      wr(`A_CTL0 + 4'h1, 16'h0000);
      test_end("core wrap");
      for (int s = 0; s < 3; s++) begin
         wr(`A_CNT0 + 4'h3, 16'h0100 + 16'(s));
         wr(`A_CAPCTL, 16'h0011 | 16'(s << 2));
         gpt_pin_model_inst.pulse(s == 0 ? 10 : (s == 1 ? 1 : 6), 1);
         rc("capture", `A_CAPTURE_RELOAD_REGISTER, 16'h0100 + 16'(s));
         rc("slave clear", `A_CNT0 + 4'h3, 16'h0000);
      end
      rc("capture flag", `A_IRQ_ST, 16'h0020);
      wr(`A_IRQ_ST, 16'h003F);
      test_end("capture");
      // A high direction pin turns an up-counting slave into a down count.
      wr(`A_CNT0 + 4'h3, 16'h0040);
      gpt_pin_model_inst.set(8, 1'b1);
      wr(`A_CTL0 + 4'h3, 16'h00A0);
      repeat (38) @(posedge clk);
      wr(`A_CTL0 + 4'h3, 16'h0000);
      rc("pin down", `A_CNT0 + 4'h3, 16'h0036);
      test_end("pin direction");
      wr(`A_CAPTURE_RELOAD_REGISTER, 16'h0050);
      wr(`A_CAPCTL, 16'h0020);
      wr(`A_IRQ_MSK, 16'h0010);
      wr(`A_CNT0 + 4'h4, 16'h0000);
      cmp_pulses = 0;
      wr(`A_CTL0 + 4'h4, 16'h4060);
      repeat (6) @(posedge clk);
      wr(`A_CTL0 + 4'h4, 16'h4000);
      rr("reload", `A_CNT0 + 4'h4, 16'h004D, 16'h0050);
      rc("under status", `A_IRQ_ST, 16'h0010);
      rc("both latches", `A_LATCH, 16'h0003);
      chk_word("master pin", 16'h0001, {15'h0000, mpin});
      chk_word("cmp pulses", 16'h0001, 16'(cmp_pulses));
      chk_word("irq master", 16'h0001, {15'h0000, irq});
      wr(`A_IRQ_MSK, 16'h0000);
      wr(`A_CTL0 + 4'h4, 16'h0000);
      repeat (3) @(posedge clk);
      chk_word("irq masked", 16'h0000, {15'h0000, irq});
      test_end("master wrap");
      // Aux high as reload source: a core wrap loads its value.
      wr(`A_CNT0 + 4'h2, 16'h1234);
      wr(`A_CTL0 + 4'h2, 16'h1000);
      wr(`A_CNT0 + 4'h1, 16'hFFFF);
      wr(`A_CTL0 + 4'h1, 16'h0020);
      repeat (8) @(posedge clk);
      wr(`A_CTL0 + 4'h1, 16'h0000);
      rr("reload core", `A_CNT0 + 4'h1, 16'h1234, 16'h1235);
      test_end("aux reload");
      // With the enable low the counter must not move at all.
      wr(`A_CNT0 + 4'h4, 16'h0000);
      wr(`A_CTL0 + 4'h4, 16'h0020);
      @(posedge clk);
      clk_en <= 1'b0;
      repeat (200) @(posedge clk);
      clk_en <= 1'b1;
      wr(`A_CTL0 + 4'h4, 16'h0000);
      rr("frozen", `A_CNT0 + 4'h4, 16'h0000, 16'h0001);
      test_end("clock enable");
      final_report();
   end
endmodule
